// ### logic/iar_consts.vh
`ifndef IAR_CONSTS_VH
`define IAR_CONSTS_VH

// register byte offsets on the ahb-lite port
`define IAR_MAP_OFS 8'h00
`define IAR_STAT_OFS 8'h04

// field positions in memory_mapping_register
`define IAR_ILOC_LSB 0
`define IAR_LLOC_LSB 2
`define IAR_IEN_BIT 4
`define IAR_LEN_BIT 5
`define IAR_XEN_BIT 6
`define IAR_MAP_W 7
// reset: i-mem at 00, l-mem at 10, both enabled, cross data access on
`define IAR_MAP_RST 7'h78

// block placement codes and anchor addresses
`define IAR_LOC_LOW_START 2'h0
`define IAR_LOC_LOW_END 2'h1
`define IAR_LOC_HIGH_START 2'h2
`define IAR_LOC_HIGH_END 2'h3
`define IAR_LOW_END_NEXT 32'h0010_0000
`define IAR_HIGH_START_ADDR 32'hfff0_0000

// control register and peripheral block: addr[31:19] match
`define IAR_CTRL_TAG 13'h1000

// routing destinations
`define IAR_DEST_IMEM 2'h0
`define IAR_DEST_LMEM 2'h1
`define IAR_DEST_EXT 2'h2
`define IAR_DEST_REG 2'h3

// least length of a cross-bus access in clocks
`define IAR_XB_CLOCKS 2'h3

`endif

// ### logic/iar_router.v
// Function
// - memory window of an absent memory goes to the external bus where no present memory shares it
// - same range, both present: every access to either memory goes external
// - same range, one present: present needs its enable, rest of the shared window goes external
// - separate ranges: present and enabled goes on-chip, otherwise external
// - each internal bus has a slave port reaching external and cross; only load/store reaches registers
// - cross-bus access takes at least three clocks
// - instruction-bus to load/store memory: at least three clocks, never burst
// - load/store masters reach instruction-bus memory and control registers
// - own register accesses wait while a cross-bus access runs
// - no overlap of external and cross cycles, no pipelined cross accesses
// - cross data access enable clear sends load/store to i-mem externally
// - two-bit location field places block at four fixed anchors
// - instruction access to control register block answers transfer error
// - unimplemented location inside a mapped memory block raises machine check
`timescale 1ns/1ps
`include "iar_consts.vh"

module iar_router #(
  parameter IMEM_LOG2 = 16,
  parameter LMEM_LOG2 = 14,
  parameter [31:0] IMEM_IMPL = 32'h0001_0000,
  parameter [31:0] LMEM_IMPL = 32'h0000_4000
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // ahb-lite register slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  // memory presence straps
  input wire IMEM_PRESENT,
  input wire LMEM_PRESENT,
  // instruction bus slave port
  input wire IB_REQ,
  input wire [31:0] IB_ADDR,
  output wire IB_ACK,
  output wire [1:0] IB_DEST,
  output wire IB_TEA,
  output wire IB_MCHK,
  // load/store bus slave port
  input wire LB_REQ,
  input wire [31:0] LB_ADDR,
  input wire LB_WR,
  output wire LB_ACK,
  output wire [1:0] LB_DEST,
  output wire LB_MCHK,
  // forwarded cycle to external bus or opposite bus
  output wire EXT_START,
  input wire EXT_DONE,
  output wire XB_BUSY,
  output wire XB_TO_LBUS,
  output wire [31:0] FWD_ADDR,
  output wire FWD_WR,
  output wire FWD_INSTR
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CROSS = 3'b010;
  localparam [2:0] ST_EXT = 3'b100;
  localparam [31:0] ISIZE = 32'h1 << IMEM_LOG2;
  localparam [31:0] LSIZE = 32'h1 << LMEM_LOG2;

  reg [`IAR_MAP_W-1:0] map_reg;
  reg [1:0] ipres_sync_reg, lpres_sync_reg;
  reg [2:0] state_reg;
  reg [1:0] cnt_reg;
  reg owner_reg, last_owner_reg;
  reg [1:0] eng_dest_reg;
  reg [31:0] fwd_addr_reg;
  reg fwd_wr_reg, fwd_instr_reg, ext_start_reg, xb_dir_reg;
  reg ib_ack_reg, ib_tea_reg, ib_mchk_reg;
  reg [1:0] ib_dest_reg;
  reg lb_ack_reg, lb_mchk_reg;
  reg [1:0] lb_dest_reg;
  reg dp_reg, dp_wr_reg, hready_reg;
  reg [7:0] dp_addr_reg;
  reg [31:0] hrdata_reg;

  wire ipres = ipres_sync_reg[1];
  wire lpres = lpres_sync_reg[1];
  wire instr_mem_enable = map_reg[`IAR_IEN_BIT];
  wire len = map_reg[`IAR_LEN_BIT];
  wire xen = map_reg[`IAR_XEN_BIT];
  wire [1:0] iloc = map_reg[`IAR_ILOC_LSB+1:`IAR_ILOC_LSB];
  wire [1:0] lloc = map_reg[`IAR_LLOC_LSB+1:`IAR_LLOC_LSB];
  // same field value puts both blocks on one anchor; with both memories present neither is used on-chip
  wire same = (iloc == lloc);
  wire cross_busy = state_reg[1];

  // block start address for each location code
  function [31:0] base_of;
    input [1:0] loc;
    input [31:0] size;
    begin
      case (loc)
        `IAR_LOC_LOW_START: base_of = 32'h0;
        `IAR_LOC_LOW_END: base_of = `IAR_LOW_END_NEXT - size;
        `IAR_LOC_HIGH_START: base_of = `IAR_HIGH_START_ADDR;
        default: base_of = 32'h0 - size;
      endcase
    end
  endfunction

  wire [31:0] ibase = base_of(iloc, ISIZE);
  wire [31:0] lbase = base_of(lloc, LSIZE);
  wire iok = ipres & instr_mem_enable & ~(same & lpres);
  wire lok = lpres & len & ~(same & ipres);

  // returns {mchk, tea, dest}; purely combinational, same cycle as request
  function [3:0] route;
    input [31:0] a;
    input from_l;
    reg [31:0] oi, ol;
    reg hi, hl;
    begin
      oi = a - ibase;
      ol = a - lbase;
      hi = ((oi >> IMEM_LOG2) == 32'h0);
      hl = ((ol >> LMEM_LOG2) == 32'h0);
      route = {2'b00, `IAR_DEST_EXT};
      if (a[31:19] == `IAR_CTRL_TAG) begin
        if (from_l)
          route = {2'b00, `IAR_DEST_REG};
        else
          route = {2'b01, `IAR_DEST_EXT};
      end else if (hi && iok) begin
        if (from_l && !xen)
          route = {2'b00, `IAR_DEST_EXT};
        else
          route = {(oi >= IMEM_IMPL), 1'b0, `IAR_DEST_IMEM};
      end else if (hl && lok) begin
        route = {(ol >= LMEM_IMPL), 1'b0, `IAR_DEST_LMEM};
      end
    end
  endfunction

  wire [3:0] i_rt = route(IB_ADDR, 1'b0);
  wire [3:0] l_rt = route(LB_ADDR, 1'b1);
  wire i_err = i_rt[3] | i_rt[2];
  wire l_err = l_rt[3];
  // engine needed for cross-bus and external cycles
  wire i_eng = ~i_err & (i_rt[1:0] != `IAR_DEST_IMEM);
  wire l_eng = ~l_err & ((l_rt[1:0] == `IAR_DEST_IMEM) ||
                         (l_rt[1:0] == `IAR_DEST_EXT));
  wire i_held = ~state_reg[0] & ~owner_reg;
  wire l_held = ~state_reg[0] & owner_reg;
  wire i_can = IB_REQ & ~ib_ack_reg & ~i_held;
  wire l_can = LB_REQ & ~lb_ack_reg & ~l_held;
  wire i_want = i_can & i_eng;
  wire l_want = l_can & l_eng;
  // alternate the shared engine so neither bus starves
  wire grant_l = l_want & (~i_want | ~last_owner_reg);
  wire grant_i = i_want & ~grant_l;
  wire i_local = i_can & ~i_eng;
  // register block on the load/store side waits out a cross access
  wire l_local = l_can & ~l_eng &
                 ~((l_rt[1:0] == `IAR_DEST_REG) & cross_busy);
  wire eng_done = (state_reg[1] & (cnt_reg == `IAR_XB_CLOCKS - 2'h1)) |
                  (state_reg[2] & EXT_DONE);
  wire g_cross = grant_l ? (l_rt[1:0] == `IAR_DEST_IMEM)
                         : (i_rt[1:0] == `IAR_DEST_LMEM);

  // presence straps come from pins: two-flop synchronisers
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ipres_sync_reg <= 2'h0;
      lpres_sync_reg <= 2'h0;
    end else begin
      ipres_sync_reg <= {ipres_sync_reg[0], IMEM_PRESENT};
      lpres_sync_reg <= {lpres_sync_reg[0], LMEM_PRESENT};
    end
  end

  // shared forwarding engine: one cycle at a time, never pipelined
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      owner_reg <= 1'b0;
      last_owner_reg <= 1'b0;
      eng_dest_reg <= `IAR_DEST_EXT;
      fwd_addr_reg <= 32'h0;
      fwd_wr_reg <= 1'b0;
      fwd_instr_reg <= 1'b0;
      ext_start_reg <= 1'b0;
      xb_dir_reg <= 1'b0;
    end else begin
      ext_start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // new work only after the previous one has fully ended
          if (grant_i || grant_l) begin
            owner_reg <= grant_l;
            last_owner_reg <= grant_l;
            eng_dest_reg <= grant_l ? l_rt[1:0] : i_rt[1:0];
            fwd_addr_reg <= grant_l ? LB_ADDR : IB_ADDR;
            fwd_wr_reg <= grant_l & LB_WR;
            fwd_instr_reg <= ~grant_l;
            xb_dir_reg <= ~grant_l;
            cnt_reg <= 2'h1;
            if (g_cross) begin
              state_reg <= ST_CROSS;
            end else begin
              state_reg <= ST_EXT;
              ext_start_reg <= 1'b1;
            end
          end
        end
        ST_CROSS: begin
          // fixed single-beat length, no burst continuation
          if (eng_done)
            state_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg + 2'h1;
        end
        ST_EXT: begin
          if (EXT_DONE)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // answers on the two internal buses, one-cycle ack pulses
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ib_ack_reg <= 1'b0;
      ib_dest_reg <= `IAR_DEST_EXT;
      ib_tea_reg <= 1'b0;
      ib_mchk_reg <= 1'b0;
      lb_ack_reg <= 1'b0;
      lb_dest_reg <= `IAR_DEST_EXT;
      lb_mchk_reg <= 1'b0;
    end else begin
      ib_ack_reg <= 1'b0;
      lb_ack_reg <= 1'b0;
      if (i_local) begin
        ib_ack_reg <= 1'b1;
        ib_dest_reg <= i_rt[1:0];
        ib_tea_reg <= i_rt[2];
        ib_mchk_reg <= i_rt[3];
      end else if (eng_done && !owner_reg) begin
        ib_ack_reg <= 1'b1;
        ib_dest_reg <= eng_dest_reg;
        ib_tea_reg <= 1'b0;
        ib_mchk_reg <= 1'b0;
      end
      if (l_local) begin
        lb_ack_reg <= 1'b1;
        lb_dest_reg <= l_rt[1:0];
        lb_mchk_reg <= l_rt[3];
      end else if (eng_done && owner_reg) begin
        lb_ack_reg <= 1'b1;
        lb_dest_reg <= eng_dest_reg;
        lb_mchk_reg <= 1'b0;
      end
    end
  end

  // ahb-lite slave; address phase accepted when hready is high
  wire accept = HSEL & HTRANS[1] & HREADY;
  wire dp_end = dp_reg & hready_reg;

  function [31:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `IAR_MAP_OFS: reg_read = {25'h0, map_reg};
        `IAR_STAT_OFS: reg_read = {27'h0, state_reg[2], cross_busy,
                                   same & ipres & lpres, lpres, ipres};
        default: reg_read = 32'h0;
      endcase
    end
  endfunction

  // register accesses are held off while a cross access owns the unit
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      dp_reg <= 1'b0;
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h0;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0;
    end else begin
      if (accept) begin
        dp_reg <= 1'b1;
        dp_wr_reg <= HWRITE;
        dp_addr_reg <= {HADDR[7:2], 2'b00};
        hready_reg <= ~cross_busy;
        hrdata_reg <= reg_read({HADDR[7:2], 2'b00});
      end else if (dp_reg && !hready_reg) begin
        if (!cross_busy) begin
          hready_reg <= 1'b1;
          hrdata_reg <= reg_read(dp_addr_reg);
        end
      end else if (dp_end) begin
        dp_reg <= 1'b0;
      end
    end
  end

  // write takes effect as the data phase ends
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      map_reg <= `IAR_MAP_RST;
    end else if (dp_end && dp_wr_reg && dp_addr_reg == `IAR_MAP_OFS) begin
      map_reg <= HWDATA[`IAR_MAP_W-1:0];
    end
  end

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hready_reg;
  assign HRESP = 1'b0;
  assign IB_ACK = ib_ack_reg;
  assign IB_DEST = ib_dest_reg;
  assign IB_TEA = ib_tea_reg;
  assign IB_MCHK = ib_mchk_reg;
  assign LB_ACK = lb_ack_reg;
  assign LB_DEST = lb_dest_reg;
  assign LB_MCHK = lb_mchk_reg;
  assign EXT_START = ext_start_reg;
  assign XB_BUSY = state_reg[1];
  assign XB_TO_LBUS = xb_dir_reg;
  assign FWD_ADDR = fwd_addr_reg;
  assign FWD_WR = fwd_wr_reg;
  assign FWD_INSTR = fwd_instr_reg;

endmodule // iar_router

// ### verif/iar_ext_model.sv
`timescale 1ns/1ps
module iar_ext_model (
  // clock and reset
  input wire clk,
  input wire rst,
  // external cycle handshake
  input wire ext_start,
  input wire [3:0] lat,
  output wire ext_done
);
  reg [3:0] cnt_reg;
  reg busy_reg;
  reg done_reg;
  assign ext_done = done_reg;
  // finish after lat idle cycles; lat 0 answers promptly
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (ext_start) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule // iar_ext_model

// ### verif/iar_router_assertions.sv
`timescale 1ns/1ps
module iar_chk (
  // clock and reset
  input wire CLK,
  input wire RST,
  // watched outputs
  input wire HREADYOUT,
  input wire IB_ACK,
  input wire [1:0] IB_DEST,
  input wire IB_TEA,
  input wire LB_ACK,
  input wire EXT_START,
  input wire XB_BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // a strobe that drops after one cycle
  sequence pulse_s(s);
    s ##1 !s;
  endsequence
  // cross transfer holds the engine exactly two busy cycles
  sequence xb_hold_s;
    XB_BUSY ##1 XB_BUSY ##1 !XB_BUSY;
  endsequence
  AST_IB_ACK_PULSE: assert property (IB_ACK |-> pulse_s(IB_ACK))
    else $error("ib ack wider than one cycle");
  AST_LB_ACK_PULSE: assert property (LB_ACK |-> pulse_s(LB_ACK))
    else $error("lb ack wider than one cycle");
  AST_EXT_PULSE: assert property (EXT_START |-> pulse_s(EXT_START))
    else $error("external start wider than one cycle");
  AST_XB_LEN: assert property ($rose(XB_BUSY) |-> xb_hold_s)
    else $error("cross access length wrong");
  AST_XB_ACK: assert property ($fell(XB_BUSY) |-> IB_ACK || LB_ACK)
    else $error("cross access ended without ack");
  AST_NO_OVERLAP: assert property (XB_BUSY |-> !EXT_START)
    else $error("external cycle overlaps cross access");
  AST_TEA_EXT: assert property (IB_ACK && IB_TEA |-> IB_DEST == 2'h2)
    else $error("transfer error with wrong destination");
  AST_REG_STALL: assert property (!HREADYOUT |-> XB_BUSY || $past(XB_BUSY))
    else $error("register stall without cross access");
endmodule // iar_chk

bind iar_router iar_chk chk_u (.CLK(CLK), .RST(RST), .HREADYOUT(HREADYOUT), .IB_ACK(IB_ACK),
  .IB_DEST(IB_DEST), .IB_TEA(IB_TEA), .LB_ACK(LB_ACK), .EXT_START(EXT_START),
  .XB_BUSY(XB_BUSY));

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk = 0, rst = 1, hsel = 0, hwrite = 0, imp = 0, lmp = 0;
  reg ib_req = 0, lb_req = 0, lb_wr = 0;
  reg [1:0] htrans = 0;
  reg [3:0] lat = 0;
  reg [31:0] haddr = 0, hwdata = 0, ib_addr = 0, lb_addr = 0;
  wire [31:0] hrdata;
  wire [1:0] ib_dest, lb_dest;
  wire hready, ib_ack, ib_tea, lb_ack, ext_start, ext_done, xb_busy;
  wire ib_mchk, lb_mchk, hresp, xb_dir, fwd_wr, fwd_instr;
  wire [31:0] fwd_addr;
  int error_cnt = 0, checks_done = 0;
  // implemented parts smaller than the windows so unimplemented holes get hit
  localparam logic [31:0] IMP_I = 32'h0000_8000;
  localparam logic [31:0] IMP_L = 32'h0000_2000;
  iar_router #(.IMEM_IMPL(IMP_I), .LMEM_IMPL(IMP_L)) dut_u (.CLK(clk), .RST(rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .IMEM_PRESENT(imp), .LMEM_PRESENT(lmp),
    .IB_REQ(ib_req), .IB_ADDR(ib_addr), .IB_ACK(ib_ack), .IB_DEST(ib_dest), .IB_TEA(ib_tea),
    .IB_MCHK(ib_mchk), .LB_REQ(lb_req), .LB_ADDR(lb_addr), .LB_WR(lb_wr), .LB_ACK(lb_ack),
    .LB_DEST(lb_dest), .LB_MCHK(lb_mchk), .EXT_START(ext_start), .EXT_DONE(ext_done),
    .XB_BUSY(xb_busy), .XB_TO_LBUS(xb_dir), .FWD_ADDR(fwd_addr), .FWD_WR(fwd_wr),
    .FWD_INSTR(fwd_instr));
  iar_ext_model ext_u (.clk(clk), .rst(rst), .ext_start(ext_start), .lat(lat),
    .ext_done(ext_done));
  initial forever #4 clk = ~clk;
  task end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // automatic: both bus tasks may compare in the same time step
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // single ahb-lite word transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // one beat on an internal bus; req held until ack seen
  task automatic req(input logic l, input logic [31:0] a, input logic w,
    output logic [3:0] r);
    @(posedge clk);
    if (l) begin
      lb_req <= 1;
      lb_addr <= a;
      lb_wr <= w;
    end else begin
      ib_req <= 1;
      ib_addr <= a;
    end
    do @(posedge clk); while ((l ? lb_ack : ib_ack) !== 1'b1);
    r = l ? {lb_mchk, 1'b0, lb_dest} : {ib_mchk, ib_tea, ib_dest};
    // forwarded cycles: attributes still hold the winner's values at the ack edge
    if (r[3:2] == 2'h0 && (r[1:0] == 2'h2 || r[1:0] == {1'b0, !l})) begin
      chk("fwd addr", a, fwd_addr);
      chk("fwd attr", {!l, l & w, !l}, {xb_dir, fwd_wr, fwd_instr});
    end
    if (l) lb_req <= 0;
    else ib_req <= 0;
  endtask
  function automatic logic [31:0] win_ofs(input logic [31:0] a, input logic [1:0] loc,
    input int lg);
    logic [31:0] sz, b;
    sz = 32'h1 << lg;
    case (loc)
      2'h0: b = 32'h0;
      2'h1: b = 32'h0010_0000 - sz;
      2'h2: b = 32'hfff0_0000;
      default: b = 32'h0 - sz;
    endcase
    return a - b;
  endfunction
  // expected {mchk, tea, destination}
  function automatic logic [3:0] exp_route(input logic l, input logic [31:0] a,
    input logic [6:0] m, input logic ip, lp);
    logic same, iok, lok;
    logic [31:0] ofi, ofl;
    same = m[1:0] == m[3:2];
    iok = ip & m[4] & !(same & lp);
    lok = lp & m[5] & !(same & ip);
    ofi = win_ofs(a, m[1:0], 16);
    ofl = win_ofs(a, m[3:2], 14);
    if (a[31:19] == 13'h1000) return l ? 4'h3 : 4'h6;
    if (ofi < 32'h0001_0000 && iok && (m[6] || !l)) return {ofi >= IMP_I, 3'h0};
    if (ofl < 32'h0000_4000 && lok) return {ofl >= IMP_L, 3'h1};
    return 4'h2;
  endfunction
  function automatic logic [31:0] pick();
    case ($urandom % 6)
      0: pick = 32'h0;
      1: pick = 32'h000f_c000;
      2: pick = 32'hfff0_0000;
      3: pick = 32'hffff_c000;
      4: pick = 32'h8000_0000;
      default: pick = $urandom;
    endcase
    pick = pick + ($urandom & 32'h3ffc);
  endfunction
  initial begin
    logic [31:0] rd, ai, al;
    logic [6:0] m;
    logic [3:0] ri, rl;
    int s;
    s = $urandom(32'hf4cf);
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    ahb(0, 32'h0, 0, rd);
    chk("map reset", 32'h78, rd);
    ahb(1, 32'h8, 32'hffff_ffff, rd);
    ahb(0, 32'h8, 0, rd);
    chk("unmapped", 32'h0, rd);
    // first sixteen: shared range with every present/enable mix
    for (int i = 0; i < 80; i++) begin
      m = (i < 16) ? {1'b1, i[1:0], 4'h0} : 7'($urandom);
      imp <= (i < 16) ? i[2] : 1'($urandom);
      lmp <= (i < 16) ? i[3] : 1'($urandom);
      lat <= 4'($urandom % 8);
      ahb(1, 32'h0, {25'h0, m}, rd);
      repeat (3) @(posedge clk);
      ai = pick();
      al = pick();
      fork
        req(0, ai, 0, ri);
        req(1, al, 1'($urandom), rl);
        // random start so some status reads land inside a cross access
        begin
          repeat ($urandom % 4) @(posedge clk);
          ahb(0, 32'h4, 0, rd);
        end
      join
      chk("status", {29'h0, m[1:0] == m[3:2] && imp && lmp, lmp, imp}, rd & 32'h7);
      chk("ib route", exp_route(0, ai, m, imp, lmp), ri);
      chk("lb route", exp_route(1, al, m, imp, lmp), rl);
    end
    ahb(0, 32'h0, 0, rd);
    chk("map readback", {25'h0, m}, rd);
    end_sim;
  end
  // hang guard, far beyond the expected run length
  initial begin
    #(8 * 30000);
    error_cnt++;
    end_sim;
  end
endmodule // testbench
